// ===== rtl/pdb_pkg.sv
// Package: constants, timing and carrier types of the parallel DMA bus-hold block
package pdb_pkg;

  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned GROUP_LEN       = 8;

  localparam int unsigned T_SETUP_FAST_NS = 200;
  localparam int unsigned T_SETUP_SLOW_NS = 400;
  localparam int unsigned T_BUSY_FAST_NS  = 300;
  localparam int unsigned T_BUSY_SLOW_NS  = 500;
  localparam int unsigned T_END_PULSE_NS  = 100;

  // Least times round up to whole cycles
  localparam int unsigned CYC_SETUP_FAST =
    (T_SETUP_FAST_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned CYC_SETUP_SLOW =
    (T_SETUP_SLOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned CYC_BUSY_FAST  =
    (T_BUSY_FAST_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned CYC_BUSY_SLOW  =
    (T_BUSY_SLOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned CYC_END_PULSE  =
    (T_END_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  localparam int unsigned TW = 5;

  // Switch defaults
  localparam logic [2:0]  IRQ_LEVEL_STD   = 3'h4;
  localparam logic [2:0]  IRQ_LEVEL_ALT   = 3'h5;
  localparam logic [21:0] DEV_ADDR_STD    = 22'o17760240;
  localparam logic [8:0]  VECTOR_STD      = 9'o300;
  localparam int unsigned ADDR_W_NARROW   = 18;
  localparam int unsigned ADDR_W_WIDE     = 22;

  // Register map of the plain register port
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_STATUS  = 4'h1;
  localparam logic [3:0] REG_IRQ_ST  = 4'h2;
  localparam logic [3:0] REG_IRQ_EN  = 4'h3;
  localparam logic [3:0] REG_IRQ_CLR = 4'h4;
  localparam logic [3:0] REG_WCOUNT  = 4'h5;
  localparam logic [3:0] REG_OUTDATA = 4'h6;
  localparam logic [3:0] REG_CONFIG  = 4'h7;
  localparam logic [3:0] REG_VECTOR  = 4'h8;

  localparam int unsigned CTRL_LAUNCH_BIT = 0;
  localparam int unsigned IRQ_W           = 3;
  localparam int unsigned IRQ_DONE_BIT    = 0;
  localparam int unsigned IRQ_ATTENTION_IN_BIT    = 1;
  localparam int unsigned IRQ_BERR_BIT    = 2;
  localparam logic [15:0] WCOUNT_RST      = 16'h0000;
  localparam logic [15:0] OUTDATA_RST     = 16'h0000;

  typedef struct packed {
    logic       burst_hold;   // Installed: release every group of eight
    logic       busy_low;     // Installed: busy is active low
    logic       slow;         // Speed jumper on slow
    logic       irq_alt;      // Closed selects the alternate level
    logic       wide_addr;    // Closed selects wide DMA addresses
  } pdb_straps_s;

  typedef struct packed {
    logic       req;
    logic       grant;
    logic       other_req;
    logic       bus_err;
  } pdb_hostbus_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARB   = 2'b01,
    ST_XFER  = 2'b10,
    ST_GAP   = 2'b11
  } pdb_state_e;

endpackage : pdb_pkg

// ===== rtl/pdb_sync.sv
// Two-flop synchroniser, one per bit
module pdb_sync
  import pdb_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        meta_q[i] <= 1'b0;
        q_o[i]    <= 1'b0;
      end else begin
        meta_q[i] <= d_i[i];
        q_o[i]    <= meta_q[i];
      end
    end
  end

endmodule : pdb_sync

// ===== rtl/pdb_dma_ctrl.sv
// Parallel DMA controller: bus hold policy, busy handshake, straps and registers
// Notes on behaviour
// - Burst strap in: drop bus mastership after each eight transfers, then re-request.
// - Burst strap out: hold the bus until the transfer ends or another requests; in single cycle mode the code holds on in ST_GAP despite such a request.
// - Strap out: a competing bus request releases the bus early; the code sees it only as a word ends, never while waiting in ST_GAP.
// - Output data valid 200ns fast, 400ns slow, before busy trailing edge.
// - Cycle mode low: busy asserted at least 300ns fast, 500ns slow per transfer.
// - Busy active low with polarity strap in, active high with it out.
// - Interrupt level 4 or 5 by switch, 4 by default.
// - DMA address width 18 or 22 bits by switch, 18 by default.
// - Registers decode at switch address, standard octal 17760240.
// - Acknowledge supplies switch vector, standard octal 300.
// - Rising edge on either ORed cycle request starts a cycle while ready low.
// - A 100ns high cycle-end pulse marks each completed data cycle.
// - Ready set by reset, attention, bus error or the word at count ffff; launch bit write clears it.
module pdb_dma_ctrl
  import pdb_pkg::*;
#(
  parameter logic [21:0] DEV_ADDR = DEV_ADDR_STD,
  parameter logic [8:0]  VECTOR   = VECTOR_STD
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [3:0]   reg_addr_i,
  input  wire logic [15:0]  reg_wdata_i,
  input  wire logic         reg_wr_i,
  input  wire logic         reg_rd_i,
  output logic      [15:0]  reg_rdata_o,
  input  wire logic [21:0]  host_addr_i,
  output logic              dev_sel_o,
  input  wire pdb_straps_s  straps_i,
  input  wire logic         bus_grant_i,
  input  wire logic         bus_other_req_i,
  input  wire logic         bus_err_i,
  input  wire logic         irq_ack_i,
  output logic              bus_req_o,
  output logic [21:0]       dma_addr_o,
  output logic              dma_strobe_o,
  output logic [2:0]        irq_level_o,
  output logic [8:0]        irq_vector_o,
  output logic              irq_o,
  input  wire logic         cycle_mode_select_i,
  input  wire logic         cycle_request_in_a_i,
  input  wire logic         cycle_request_in_b_i,
  input  wire logic         attention_in_i,
  output logic [15:0]       data_out_o,
  output logic              busy_o,
  output logic              ready_o,
  output logic              cycle_end_pulse_o
);

  // Pins from the user side and the strap block pass two flops first
  logic [10:0]  sync_s;
  pdb_straps_s  straps_s;
  logic         mode_s, rq_s, attention_in_s, grant_s, other_s, berr_s;

  pdb_sync #(.W(11)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({cycle_mode_select_i, cycle_request_in_a_i | cycle_request_in_b_i,
             attention_in_i, bus_grant_i, bus_other_req_i, bus_err_i, straps_i}),
    .q_o   (sync_s)
  );
  assign {mode_s, rq_s, attention_in_s, grant_s, other_s, berr_s} = sync_s[10:5];
  // Straps are pins as well; a jumper moved under power must not glitch the logic
  assign straps_s = sync_s[4:0];

  pdb_state_e   state_q;
  logic         rq_q, attention_in_q, berr_q;
  logic         ready_q, busy_act_q;
  logic [TW-1:0] tmr_q;
  logic [2:0]   grp_q;
  logic [15:0]  wcount_q, outdata_q;
  logic [21:0]  addr_q;
  logic [IRQ_W-1:0] irq_st_q, irq_en_q, irq_set;
  logic         rq_rise, attention_in_rise, berr_rise, xfer_done, start_dma;
  logic         launch_wr, pace_ok;
  logic [TW-1:0] t_setup, t_busy;
  logic [2:0]   end_cnt_q;
  logic         req_off_q;

  assign rq_rise   = rq_s & ~rq_q;
  assign attention_in_rise = attention_in_s & ~attention_in_q;
  assign berr_rise = berr_s & ~berr_q && state_q != ST_IDLE;
  assign launch_wr = reg_wr_i && reg_addr_i == REG_CTRL && reg_wdata_i[CTRL_LAUNCH_BIT];

  // Slow setting stretches both figures to keep the user from overrunning
  assign t_setup = straps_s.slow ? TW'(CYC_SETUP_SLOW) : TW'(CYC_SETUP_FAST);
  assign t_busy  = straps_s.slow ? TW'(CYC_BUSY_SLOW)  : TW'(CYC_BUSY_FAST);
  assign pace_ok = tmr_q >= t_setup && tmr_q >= t_busy;

  // After a release the request stays down until the old grant is seen gone,
  // so the arbiter always sees a gap between two tenures
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_off_q <= 1'b1;
    end else if (state_q != ST_ARB) begin
      req_off_q <= 1'b1;
    end else if (!grant_s) begin
      req_off_q <= 1'b0;
    end
  end

  // Edge detectors reset to the pins' idle level, so reset leaves no false start
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rq_q   <= 1'b0;
      attention_in_q <= 1'b0;
      berr_q <= 1'b0;
    end else begin
      rq_q   <= rq_s;
      attention_in_q <= attention_in_s;
      berr_q <= berr_s;
    end
  end

  // Ready: reset sets it; attention, bus error in DMA or the word at count ffff sets it; launch clears
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_q <= 1'b1;
    end else if (attention_in_rise || berr_rise) begin
      ready_q <= 1'b1;
    end else if (xfer_done) begin
      ready_q <= 1'b1;
    end else if (launch_wr) begin
      ready_q <= 1'b0;
    end
  end

  // A start needs ready low; in single cycle mode a word waits for its own request unless it follows a re-arbitration
  assign start_dma = rq_rise && !ready_q;

  // Host bus hold and the busy handshake
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q    <= ST_IDLE;
      tmr_q      <= '0;
      grp_q      <= '0;
      busy_act_q <= 1'b0;
      wcount_q   <= WCOUNT_RST;
      addr_q     <= '0;
      xfer_done  <= 1'b0;
    end else begin
      xfer_done <= 1'b0;
      if (launch_wr) begin
        wcount_q <= wcount_q;
      end
      case (state_q)
        ST_IDLE: begin
          if (start_dma) begin
            state_q <= ST_ARB;
          end
        end
        ST_ARB: begin
          if (ready_q) begin
            state_q <= ST_IDLE;
          end else if (grant_s && !req_off_q) begin
            // Each tenure opens a fresh group count
            grp_q      <= '0;
            tmr_q      <= '0;
            busy_act_q <= 1'b1;
            state_q    <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (tmr_q != '1) begin
            tmr_q <= tmr_q + TW'(1);
          end
          // An abort drops the word in flight; count and address stay put
          if (ready_q) begin
            busy_act_q <= 1'b0;
            state_q    <= ST_IDLE;
          end else if (pace_ok) begin
            busy_act_q <= 1'b0;
            wcount_q   <= wcount_q + 16'h0001;
            addr_q     <= addr_q + 22'h2;
            grp_q      <= grp_q + 3'h1;
            if (wcount_q == 16'hffff) begin
              xfer_done <= 1'b1;
              state_q   <= ST_IDLE;
            end else if (straps_s.burst_hold && grp_q == 3'(GROUP_LEN - 1)) begin
              state_q <= ST_ARB;
            end else if (other_s) begin
              state_q <= ST_ARB;
            end else begin
              state_q <= ST_GAP;
            end
          end
        end
        ST_GAP: begin
          tmr_q <= '0;
          if (ready_q) begin
            state_q <= ST_IDLE;
          end else if (mode_s && !rq_rise) begin
            state_q <= ST_GAP;
          end else begin
            busy_act_q <= 1'b1;
            state_q    <= ST_XFER;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Cycle end pulse, four cycles of 25 ns
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      end_cnt_q         <= '0;
      cycle_end_pulse_o <= 1'b0;
    end else if (state_q == ST_XFER && pace_ok && !ready_q) begin
      end_cnt_q         <= 3'(CYC_END_PULSE - 1);
      cycle_end_pulse_o <= 1'b1;
    end else if (end_cnt_q != '0) begin
      end_cnt_q <= end_cnt_q - 3'h1;
    end else begin
      cycle_end_pulse_o <= 1'b0;
    end
  end

  // Interrupt status: set wins over clear
  assign irq_set = {berr_rise, attention_in_rise, xfer_done};
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_st_q <= '0;
      irq_en_q <= '0;
    end else begin
      if (reg_wr_i && reg_addr_i == REG_IRQ_EN) begin
        irq_en_q <= reg_wdata_i[IRQ_W-1:0];
      end
      if (reg_wr_i && reg_addr_i == REG_IRQ_CLR) begin
        irq_st_q <= (irq_st_q & ~reg_wdata_i[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_st_q <= irq_st_q | irq_set;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      outdata_q <= OUTDATA_RST;
    end else if (reg_wr_i && reg_addr_i == REG_OUTDATA) begin
      outdata_q <= reg_wdata_i;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_req_o    <= 1'b0;
      dma_addr_o   <= '0;
      dma_strobe_o <= 1'b0;
      irq_level_o  <= IRQ_LEVEL_STD;
      irq_vector_o <= '0;
      irq_o        <= 1'b0;
      data_out_o   <= OUTDATA_RST;
      busy_o       <= 1'b0;
      ready_o      <= 1'b1;
      dev_sel_o    <= 1'b0;
    end else begin
      bus_req_o    <= (state_q == ST_ARB && !req_off_q) || state_q == ST_XFER ||
                      state_q == ST_GAP;
      dma_addr_o   <= straps_s.wide_addr ? addr_q :
                      {4'h0, addr_q[ADDR_W_NARROW-1:0]};
      dma_strobe_o <= state_q == ST_XFER && pace_ok && !ready_q;
      irq_level_o  <= straps_s.irq_alt ? IRQ_LEVEL_ALT : IRQ_LEVEL_STD;
      irq_vector_o <= irq_ack_i ? VECTOR : 9'h000;
      irq_o        <= |(irq_st_q & irq_en_q);
      data_out_o   <= outdata_q;
      busy_o       <= busy_act_q ^ straps_s.busy_low;
      ready_o      <= ready_q;
      dev_sel_o    <= host_addr_i == DEV_ADDR;
    end
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        REG_CTRL:    reg_rdata_o <= {15'h0, ~ready_q};
        REG_STATUS:  reg_rdata_o <= {10'h0, state_q, grp_q, ready_q};
        REG_IRQ_ST:  reg_rdata_o <= {13'h0, irq_st_q};
        REG_IRQ_EN:  reg_rdata_o <= {13'h0, irq_en_q};
        REG_WCOUNT:  reg_rdata_o <= wcount_q;
        REG_OUTDATA: reg_rdata_o <= outdata_q;
        REG_CONFIG:  reg_rdata_o <= {11'h0, straps_s};
        REG_VECTOR:  reg_rdata_o <= {7'h0, VECTOR};
        default:     reg_rdata_o <= '0;
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end

endmodule : pdb_dma_ctrl

// ===== testbench/pdb_partner.sv
// Far-side model: host bus arbiter and user equipment pacing
module pdb_partner
  import pdb_pkg::*;
#(
  parameter int unsigned WAIT = 3
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic bus_req_i,
  input  wire logic end_i,
  input  wire logic kick_i,
  input  wire logic pace_i,
  output logic      grant_o,
  output logic      req_a_o,
  output logic      req_b_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] wait_q;
  logic       end_q;
  // Grant comes a few cycles after the request and is withdrawn with it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_q  <= 4'h0;
      grant_o <= 1'b0;
    end else begin
      wait_q  <= bus_req_i ? wait_q + 4'(wait_q != 4'hf) : 4'h0;
      grant_o <= bus_req_i && (wait_q >= 4'(WAIT));
    end
  end
  // Starts are one-cycle pulses, so every start is a fresh edge
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      end_q   <= 1'b0;
      req_a_o <= 1'b0;
      req_b_o <= 1'b0;
    end else begin
      end_q   <= end_i;
      req_a_o <= kick_i;
      req_b_o <= pace_i && end_q && !end_i;
    end
  end
endmodule : pdb_partner

// ===== testbench/pdb_dma_ctrl_asserts.sv
// Port checker for the parallel DMA bus-hold controller
module pdb_dma_ctrl_asserts
  import pdb_pkg::*;
#(
  parameter logic [21:0] DEV_ADDR = DEV_ADDR_STD,
  parameter logic [8:0]  VECTOR   = VECTOR_STD
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [3:0]  reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic [21:0] host_addr_i,
  input wire logic        dev_sel_o,
  input wire pdb_straps_s straps_i,
  input wire logic        bus_other_req_i,
  input wire logic        irq_ack_i,
  input wire logic        bus_req_o,
  input wire logic        dma_strobe_o,
  input wire logic [2:0]  irq_level_o,
  input wire logic [8:0]  irq_vector_o,
  input wire logic        attention_in_i,
  input wire logic        busy_o,
  input wire logic        ready_o,
  input wire logic        cycle_end_pulse_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic       act;
  logic [4:0] busy_q;
  logic [4:0] grp_q;
  logic [2:0] settle_q;
  assign act = busy_o ^ straps_i.busy_low;
  // Straps pass synchronisers, so the busy width and level checks wait for them
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      settle_q <= 3'h0;
      busy_q   <= 5'h0;
      grp_q    <= 5'h0;
    end else begin
      settle_q <= settle_q + 3'(settle_q != 3'h7);
      busy_q   <= act ? busy_q + 5'(busy_q != 5'h1f) : 5'h0;
      grp_q    <= bus_req_o ? grp_q + 5'(dma_strobe_o) : 5'h0;
    end
  end
  sequence end_hold;
    cycle_end_pulse_o [*4] ##1 !cycle_end_pulse_o;
  endsequence
  ready_reset_a: assert property ($fell(rst_i) |-> ready_o)
    else $error("ready low after reset");
  launch_clear_a: assert property (reg_wr_i && reg_addr_i == REG_CTRL &&
    reg_wdata_i[CTRL_LAUNCH_BIT] && !attention_in_i |=> ##1 !ready_o)
    else $error("launch did not clear ready");
  attention_in_ready_a: assert property ($rose(attention_in_i) |-> ##[1:8] ready_o)
    else $error("attention did not set ready");
  end_pulse_a: assert property ($rose(cycle_end_pulse_o) |-> end_hold)
    else $error("cycle end pulse width wrong");
  // Judged at each word's strobe, so an abort by ready is not held to the minimum
  busy_width_a: assert property (dma_strobe_o && settle_q == 3'h7 |->
    busy_q >= (straps_i.slow ? CYC_BUSY_SLOW : CYC_BUSY_FAST))
    else $error("busy too short");
  group_len_a: assert property (straps_i.burst_hold |-> grp_q <= 5'(GROUP_LEN))
    else $error("more than a group per tenure");
  other_release_a: assert property (bus_other_req_i && bus_req_o |-> ##[1:40] !bus_req_o)
    else $error("bus not released");
  vector_ack_a: assert property (settle_q != 3'h0 |->
    irq_vector_o == ($past(irq_ack_i) ? VECTOR : 9'h0))
    else $error("vector wrong");
  irq_level_a: assert property (settle_q == 3'h7 |->
    irq_level_o == (straps_i.irq_alt ? IRQ_LEVEL_ALT : IRQ_LEVEL_STD))
    else $error("interrupt level wrong");
  dev_sel_a: assert property (settle_q != 3'h0 |->
    dev_sel_o == ($past(host_addr_i) == DEV_ADDR))
    else $error("device select wrong");
endmodule : pdb_dma_ctrl_asserts

// ===== testbench/pdb_dma_ctrl_tb.sv
// Self-checking bench of the parallel DMA bus-hold controller
module pdb_dma_ctrl_tb
  import pdb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, irq_ack_i = 1'b0;
  logic bus_other_req_i = 1'b0, bus_err_i = 1'b0, cycle_mode_select_i = 1'b0;
  logic attention_in_i = 1'b0, kick = 1'b0, pace = 1'b0, req_p = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [15:0] reg_wdata_i = 16'h0, v;
  logic [21:0] host_addr_i = 22'h0;
  pdb_straps_s straps_i = 5'b11000;
  logic bus_grant_i, cycle_request_in_a_i, cycle_request_in_b_i, dev_sel_o, bus_req_o;
  logic dma_strobe_o, irq_o, busy_o, ready_o, cycle_end_pulse_o;
  logic [15:0] reg_rdata_o, data_out_o;
  logic [21:0] dma_addr_o;
  logic [2:0] irq_level_o;
  logic [8:0] irq_vector_o;
  int errors = 0, check_count = 0, nst = 0, ten = 0, tmax = 0, rel = 0;
  pdb_dma_ctrl dut (.*);
  pdb_partner far (.clk_i(clk_i), .rst_i(rst_i), .bus_req_i(bus_req_o),
    .end_i(cycle_end_pulse_o), .kick_i(kick), .pace_i(pace), .grant_o(bus_grant_i),
    .req_a_o(cycle_request_in_a_i), .req_b_o(cycle_request_in_b_i));
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // Strobes per tenure; counted before the reset so a drop on the last word still counts
  always @(posedge clk_i) begin
    ten += int'(dma_strobe_o);
    nst += int'(dma_strobe_o);
    tmax = (ten > tmax) ? ten : tmax;
    ten = bus_req_o ? ten : 0;
    rel += int'(req_p && !bus_req_o);
    req_p = bus_req_o;
  end
  // Called at a clock edge: values seen are those settled in the cycle before
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
    // Outputs fed by a written register are registered once more
    @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_i);
    d = reg_rdata_o;
  endtask : rd
  task automatic boot(input pdb_straps_s s);
    straps_i <= s;
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask : boot
  task automatic run(input int n);
    wr(REG_CTRL, 16'h0001);
    kick <= 1'b1;
    @(posedge clk_i);
    kick <= 1'b0;
    nst = 0;
    tmax = 0;
    repeat (n) @(posedge clk_i);
  endtask : run
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (12000) @(posedge clk_i);
    errors++;
    complete_run;
  end
  initial begin
    boot(5'b11000);
    chk("ready", 16'h1, 16'(ready_o));
    chk("busy idle", 16'h1, 16'(busy_o));
    chk("level", 16'(IRQ_LEVEL_STD), 16'(irq_level_o));
    rd(REG_WCOUNT, v);
    chk("wcount", WCOUNT_RST, v);
    rd(4'hf, v);
    chk("unmapped", 16'h0, v);
    wr(REG_OUTDATA, 16'ha5c3);
    chk("outdata", 16'ha5c3, data_out_o);
    host_addr_i <= DEV_ADDR_STD;
    irq_ack_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("dev sel", 16'h1, 16'(dev_sel_o));
    chk("vector", 16'(VECTOR_STD), 16'(irq_vector_o));
    irq_ack_i <= 1'b0;
    rd(REG_VECTOR, v);
    chk("vector reg", 16'(VECTOR_STD), v);
    run(400);
    chk("group", 16'(GROUP_LEN), 16'(tmax));
    attention_in_i <= 1'b1;
    repeat (40) @(posedge clk_i);
    attention_in_i <= 1'b0;
    chk("ready attention_in", 16'h1, 16'(ready_o));
    rd(REG_WCOUNT, v);
    chk("wcount", 16'(nst), v);
    chk("dma addr", 16'(2 * nst), dma_addr_o[15:0]);
    rd(REG_IRQ_ST, v);
    chk("irq status", 16'h2, v);
    chk("irq masked", 16'h0, 16'(irq_o));
    wr(REG_IRQ_EN, 16'h2);
    chk("irq on", 16'h1, 16'(irq_o));
    wr(REG_IRQ_CLR, 16'h2);
    chk("irq clear", 16'h0, 16'(irq_o));
    boot(5'b00110);
    chk("busy idle", 16'h0, 16'(busy_o));
    chk("level", 16'(IRQ_LEVEL_ALT), 16'(irq_level_o));
    rd(REG_CONFIG, v);
    chk("config", 16'h0006, v);
    run(600);
    chk("no group cap", 16'h1, 16'(tmax > GROUP_LEN));
    rel = 0;
    bus_other_req_i <= 1'b1;
    repeat (60) @(posedge clk_i);
    bus_other_req_i <= 1'b0;
    chk("release", 16'h1, 16'(rel > 0));
    bus_err_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    bus_err_i <= 1'b0;
    chk("ready err", 16'h1, 16'(ready_o));
    rd(REG_IRQ_ST, v);
    chk("irq err", 16'h4, v);
    // Single-cycle mode: one start edge must yield one word only
    boot(5'b11000);
    cycle_mode_select_i <= 1'b1;
    run(200);
    chk("single", 16'h1, 16'(nst));
    pace <= 1'b1;
    kick <= 1'b1;
    @(posedge clk_i);
    kick <= 1'b0;
    repeat (300) @(posedge clk_i);
    chk("paced", 16'h1, 16'(nst > 4));
    complete_run;
  end
endmodule : pdb_dma_ctrl_tb
bind pdb_dma_ctrl pdb_dma_ctrl_asserts #(.DEV_ADDR(DEV_ADDR), .VECTOR(VECTOR)) props (.*);
